//--- rtl/sflash_front_end.sv
`timescale 1ns/100ps
module sflash_front_end #(
  parameter logic [7:0] MFR_CODE   = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_TYPE   = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CAP    = 8'h13, // arbitrary value
  parameter logic [7:0] DEV_SIG    = 8'h13, // arbitrary value
  parameter int         FIFO_DEPTH = sflash_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          cs_n,
  input  wire logic                          sclk,
  input  wire logic                          serial_in_io0_in,
  output logic                               serial_in_io0_out,
  output logic                               serial_in_io0_oe_n,
  input  wire logic                          serial_out_io1_in,
  output logic                               serial_out_io1_out,
  output logic                               serial_out_io1_oe_n,
  input  wire logic                          write_protect_n_io2_in,
  output logic                               write_protect_n_io2_out,
  output logic                               write_protect_n_io2_oe_n,
  input  wire logic                          pause_n_io3_in,
  output logic                               pause_n_io3_out,
  output logic                               pause_n_io3_oe_n,
  output logic [sflash_pkg::ARRAY_AW-1:0]    array_rd_addr,
  input  wire logic [7:0]                    array_rd_data,
  output logic                               prog_valid,
  input  wire logic                          prog_ready,
  output logic [7:0]                         prog_data,
  output logic                               op_start,
  output sflash_pkg::op_kind_e               op_kind,
  output logic [sflash_pkg::ARRAY_AW-1:0]    op_addr,
  output logic                               page_cancel,
  input  wire logic                          array_done,
  output logic                               standby,
  output logic                               op_in_progress_flag,
  output logic                               write_enable_latch,
  output logic [3:0]                         block_protect_bits,
  output logic                               quad_enable
);
  import sflash_pkg::*;

  typedef enum logic [2:0] {
    ST_CMD, ST_DEC, ST_ADDR, ST_DUMMY, ST_DIN, ST_DOUT, ST_IDLE
  } fe_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] cs_sy;
  logic [1:0] sck_sy;
  logic [3:0] io_a;
  logic [3:0] io_b;
  logic       cs_d;
  logic       sck_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_sy  <= 2'h3;
      sck_sy <= 2'h0;
      io_a   <= 4'hF;
      io_b   <= 4'hF;
      cs_d   <= 1'b1;
      sck_d  <= 1'b0;
    end else begin
      cs_sy  <= {cs_sy[0], cs_n};
      sck_sy <= {sck_sy[0], sclk};
      io_a   <= {pause_n_io3_in, write_protect_n_io2_in,
                 serial_out_io1_in, serial_in_io0_in};
      io_b   <= io_a;
      cs_d   <= cs_sy[1];
      sck_d  <= sck_sy[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and decode
  fe_state_e  st_reg;
  fe_state_e  st_next;
  logic [7:0] cmd_reg;
  logic [7:0] sh_reg;
  logic [2:0] bcnt_reg;
  logic [4:0] cnt_reg;
  logic [23:0] addr_reg;
  logic       bad_reg;
  logic       got_reg;
  logic [7:0] stat_in_reg;
  logic [8:0] pcnt_reg;
  logic [2:0] ocnt_reg;
  logic [7:0] out_sh_reg;
  logic [1:0] idx_reg;
  logic [3:0] io_o_reg;
  logic [3:0] oe_n_reg;
  logic       wel_reg;
  logic       wip_reg;
  logic       status_write_disable_bit_reg;
  logic       qe_reg;
  logic [3:0] bp_reg;
  logic       op_start_reg;
  op_kind_e   op_kind_reg;
  logic [23:0] op_addr_reg;
  logic       cancel_reg;
  byte_fifo_if #(.W(DATA_W)) fifo ();

  wire sel      = !cs_sy[1];
  wire cs_rise  = cs_sy[1] && !cs_d;
  wire cs_fall  = !cs_sy[1] && cs_d;
  wire c_quad   = cmd_reg == CMD_READ_QUAD || cmd_reg == CMD_MFR_DEV_READ_QUAD;
  wire c_dual   = cmd_reg == CMD_READ_DUAL || cmd_reg == CMD_MFR_DEV_READ_DUAL;
  wire quad_live = st_reg != ST_CMD && c_quad;
  wire paused   = sel && !io_b[3] && !quad_live;
  wire rise     = sel && sck_sy[1] && !sck_d && !paused;
  wire fall     = sel && !sck_sy[1] && sck_d && !paused;

  wire [2:0] c_lanes = c_quad ? 3'h4 : c_dual ? 3'h2 : 3'h1;
  wire [2:0] lanes   = st_reg == ST_CMD ? 3'h1 : c_lanes;
  wire c_arr = cmd_reg == CMD_READ || cmd_reg == CMD_READ_FAST || c_dual
               && cmd_reg == CMD_READ_DUAL || cmd_reg == CMD_READ_QUAD;
  wire c_mfr = cmd_reg == CMD_MFR_DEV_READ
               || cmd_reg == CMD_MFR_DEV_READ_DUAL
               || cmd_reg == CMD_MFR_DEV_READ_QUAD;
  wire c_chip = cmd_reg == CMD_ERASE_CHIP || cmd_reg == CMD_ERASE_CHIP_ALT;
  wire op_kind_e c_kind =
      cmd_reg == CMD_PROGRAM      ? OP_PAGE   :
      cmd_reg == CMD_ERASE_SECTOR ? OP_SECTOR :
      cmd_reg == CMD_ERASE_32K    ? OP_BLK32  :
      cmd_reg == CMD_ERASE_64K    ? OP_BLK64  :
      c_chip                      ? OP_CHIP   : OP_NONE;
  wire c_op   = c_kind != OP_NONE;
  wire c_addr = c_arr || c_mfr || (c_op && !c_chip);
  wire c_out  = c_arr || c_mfr || cmd_reg == CMD_STATUS_READ
                || cmd_reg == CMD_IDENTIFICATION_READ
                || cmd_reg == CMD_SIGNATURE_READ;
  wire c_in   = cmd_reg == CMD_STATUS_WRITE || cmd_reg == CMD_PROGRAM;
  wire [4:0] c_dummy =
      cmd_reg == CMD_READ_FAST      ? DUMMY_FAST :
      cmd_reg == CMD_READ_DUAL      ? DUMMY_DUAL :
      cmd_reg == CMD_READ_QUAD      ? DUMMY_QUAD :
      cmd_reg == CMD_SIGNATURE_READ ? DUMMY_SIG  : 5'h00;
  wire fe_state_e after_addr = c_dummy != 5'h00 ? ST_DUMMY :
                               c_out ? ST_DOUT : c_in ? ST_DIN : ST_IDLE;
  wire busy_block = wip_reg && cmd_reg != CMD_STATUS_READ;

  ////////////////////////////////////////////////////////////////////////////
  // input shifting
  // msb first into shifter
  wire [7:0] sh_nx = lanes == 3'h4 ? {sh_reg[3:0], io_b}        :
                     lanes == 3'h2 ? {sh_reg[5:0], io_b[1:0]}   :
                                     {sh_reg[6:0], io_b[0]};
  wire [23:0] addr_nx = lanes == 3'h4 ? {addr_reg[19:0], io_b}      :
                        lanes == 3'h2 ? {addr_reg[21:0], io_b[1:0]} :
                                        {addr_reg[22:0], io_b[0]};
  wire [3:0] bsum     = {1'b0, bcnt_reg} + {1'b0, lanes};
  wire       byte_end = bsum[3];
  wire [4:0] asum     = cnt_reg + {2'h0, lanes};
  wire [4:0] dsum     = cnt_reg + 5'h01;
  wire       shifting = rise && (st_reg == ST_CMD || st_reg == ST_DIN);
  wire       din_byte = rise && byte_end && st_reg == ST_DIN;
  wire       push = din_byte && cmd_reg == CMD_PROGRAM
                    && pcnt_reg != PAGE_BYTES;

  always_comb begin
    st_next = st_reg;
    if (cs_fall) begin
      st_next = ST_CMD;
    end else begin
      case (st_reg)
        ST_CMD: if (rise && byte_end) st_next = ST_DEC;
        ST_DEC: st_next = busy_block ? ST_IDLE :
                          c_addr ? ST_ADDR : after_addr;
        ST_ADDR: if (rise && asum == ADDR_BITS) st_next = after_addr;
        ST_DUMMY: if (rise && dsum == c_dummy) st_next = ST_DOUT;
        default: st_next = st_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= ST_CMD;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || st_next != st_reg) begin
      cnt_reg <= 5'h00;
    end else if (rise && st_reg == ST_ADDR) begin
      cnt_reg <= asum;
    end else if (rise && st_reg == ST_DUMMY) begin
      cnt_reg <= dsum;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cs_fall) begin
      bcnt_reg <= 3'h0;
      sh_reg   <= 8'h00;
    end else if (shifting) begin
      bcnt_reg <= bsum[2:0];
      sh_reg   <= sh_nx;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_reg <= 8'h00;
    end else if (rise && byte_end && st_reg == ST_CMD) begin
      cmd_reg <= sh_nx;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cs_fall) begin
      bad_reg <= 1'b0;
    end else if ((st_reg == ST_DEC && busy_block)
                 || (rise && st_reg == ST_IDLE)
                 || (push && !fifo.in_ready)) begin
      bad_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cs_fall) begin
      got_reg     <= 1'b0;
      stat_in_reg <= 8'h00;
      pcnt_reg    <= 9'h000;
    end else begin
      if (din_byte && cmd_reg == CMD_STATUS_WRITE && !got_reg) begin
        got_reg     <= 1'b1;
        stat_in_reg <= sh_nx;
      end
      if (push) begin
        pcnt_reg <= pcnt_reg + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output shifting
  wire [7:0] status = {status_write_disable_bit_reg, qe_reg, bp_reg, wel_reg, wip_reg};
  wire [7:0] id_byte = idx_reg == 2'h0 ? MFR_CODE :
                       idx_reg == 2'h1 ? DEV_TYPE : DEV_CAP;
  wire [7:0] md_byte = (addr_reg[0] ^ idx_reg[0]) ? DEV_SIG : MFR_CODE;
  wire [7:0] src = c_arr ? array_rd_data :
                   cmd_reg == CMD_STATUS_READ ? status :
                   cmd_reg == CMD_IDENTIFICATION_READ ? id_byte :
                   cmd_reg == CMD_SIGNATURE_READ ? DEV_SIG : md_byte;
  wire       dfall = fall && st_reg == ST_DOUT;
  wire       load  = dfall && ocnt_reg == 3'h0;
  wire [7:0] word  = ocnt_reg == 3'h0 ? src : out_sh_reg;
  wire [3:0] io_nx = lanes == 3'h4 ? word[7:4] :
                     lanes == 3'h2 ? {2'h0, word[7:6]} :
                                     {2'h0, word[7], 1'b0};
  wire [3:0] oe_nx = lanes == 3'h4 ? 4'h0 : lanes == 3'h2 ? 4'hC : 4'hD;
  wire [1:0] idx_nx = (cmd_reg == CMD_IDENTIFICATION_READ
                       && idx_reg == 2'h2) ? 2'h0 : idx_reg + 2'h1;

  always_ff @(posedge clk) begin
    if (sys_rst || cs_fall) begin
      ocnt_reg   <= 3'h0;
      out_sh_reg <= 8'h00;
      idx_reg    <= 2'h0;
    end else if (dfall) begin
      ocnt_reg   <= ocnt_reg + lanes;
      out_sh_reg <= word << lanes;
      if (load) begin
        idx_reg <= idx_nx;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_reg <= 24'h000000;
    end else if (rise && st_reg == ST_ADDR) begin
      addr_reg <= addr_nx;
    end else if (load && c_arr) begin
      addr_reg <= addr_reg + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_o_reg <= 4'h0;
      oe_n_reg <= 4'hF;
    end else if (!sel || paused) begin
      oe_n_reg <= 4'hF;
    end else if (dfall) begin
      io_o_reg <= io_nx;
      oe_n_reg <= oe_nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commit at deselect
  wire [2:0] blk = addr_reg[18:16];
  wire prot_blk = bp_reg == 4'h0 ? 1'b0 :
                  bp_reg == 4'h1 ? blk == 3'h7 :
                  bp_reg == 4'h2 ? blk >= 3'h6 :
                  bp_reg == 4'h3 ? blk >= 3'h4 :
                  bp_reg == 4'hC ? blk <= 3'h3 :
                  bp_reg == 4'hD ? blk <= 3'h5 :
                  bp_reg == 4'hE ? blk <= 3'h6 : 1'b1;
  wire prot_hit = c_chip ? bp_reg != 4'h0 : prot_blk;
  wire aligned  = !bad_reg && (st_reg == ST_IDLE
                  || (st_reg == ST_DIN && bcnt_reg == 3'h0));
  wire commit   = cs_rise && aligned && !wip_reg;
  wire hw_lock  = status_write_disable_bit_reg && !io_b[2] && !qe_reg;
  wire stat_ok  = commit && cmd_reg == CMD_STATUS_WRITE && got_reg
                  && wel_reg && !hw_lock;
  wire op_ok    = commit && c_op && wel_reg && !prot_hit
                  && (cmd_reg != CMD_PROGRAM || pcnt_reg != 9'h000);
  wire cancel   = cs_rise && st_reg != ST_CMD
                  && cmd_reg == CMD_PROGRAM && !op_ok && !wip_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wel_reg <= 1'b0;
    end else if (commit && cmd_reg == CMD_WRITE_ENABLE) begin
      wel_reg <= 1'b1;
    end else if ((commit && cmd_reg == CMD_WRITE_DISABLE)
                 || stat_ok || op_ok) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_write_disable_bit_reg <= 1'b0;
      qe_reg   <= 1'b0;
      bp_reg   <= BP_RST;
    end else if (stat_ok) begin
      status_write_disable_bit_reg <= stat_in_reg[7];
      qe_reg   <= stat_in_reg[6];
      bp_reg   <= stat_in_reg[5:2];
    end
  end

  // array runs timed op and verify
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wip_reg <= 1'b0;
    end else if (op_ok) begin
      wip_reg <= 1'b1;
    end else if (array_done) begin
      wip_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_start_reg <= 1'b0;
      op_kind_reg  <= OP_NONE;
      op_addr_reg  <= 24'h000000;
      cancel_reg   <= 1'b0;
    end else begin
      op_start_reg <= op_ok;
      cancel_reg   <= cancel;
      if (op_ok) begin
        op_kind_reg <= c_kind;
        op_addr_reg <= addr_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program data buffer
  assign fifo.in_valid  = push;
  assign fifo.in_data   = sh_nx;
  assign fifo.flush     = cancel;
  assign fifo.out_ready = prog_ready;

  sflash_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .port    (fifo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prog_valid               = fifo.out_valid;
  assign prog_data                = fifo.out_data;
  assign array_rd_addr            = addr_reg[ARRAY_AW-1:0];
  assign op_start                 = op_start_reg;
  assign op_kind                  = op_kind_reg;
  assign op_addr                  = op_addr_reg[ARRAY_AW-1:0];
  assign page_cancel              = cancel_reg;
  assign standby                  = cs_sy[1] && !wip_reg;
  assign op_in_progress_flag      = wip_reg;
  assign write_enable_latch       = wel_reg;
  assign block_protect_bits       = bp_reg;
  assign quad_enable              = qe_reg;
  assign serial_in_io0_out        = io_o_reg[0];
  assign serial_out_io1_out       = io_o_reg[1];
  assign write_protect_n_io2_out  = io_o_reg[2];
  assign pause_n_io3_out          = io_o_reg[3];
  assign serial_in_io0_oe_n       = oe_n_reg[0];
  assign serial_out_io1_oe_n      = oe_n_reg[1];
  assign write_protect_n_io2_oe_n = oe_n_reg[2];
  assign pause_n_io3_oe_n         = oe_n_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_latch_drop_op: assert property (
    op_ok |=> !wel_reg && op_start_reg && wip_reg)
    else $error("latch or flag wrong after op start");
  a_start_had_latch: assert property (
    op_start_reg |-> $past(wel_reg, 1))
    else $error("op started without latch");
  a_flag_holds: assert property (
    wip_reg && !array_done && !op_ok |=> wip_reg)
    else $error("flag dropped before array done");
  a_chip_unprotected: assert property (
    op_start_reg && op_kind_reg == OP_CHIP |-> bp_reg == 4'h0)
    else $error("chip erase under protection");
  a_partial_void: assert property (
    cs_rise && st_reg == ST_DIN && bcnt_reg != 3'h0
    |=> !op_start_reg && $stable(bp_reg))
    else $error("partial byte command acted");
  a_fast_dummy: assert property (
    $rose(st_reg == ST_DOUT) && cmd_reg == CMD_READ_FAST
    |-> $past(cnt_reg, 1) == 5'h07)
    else $error("fast read dummy count wrong");
  a_dual_dummy: assert property (
    $rose(st_reg == ST_DOUT) && cmd_reg == CMD_READ_DUAL
    |-> $past(cnt_reg, 1) == 5'h03)
    else $error("dual read dummy count wrong");
  a_quad_dummy: assert property (
    $rose(st_reg == ST_DOUT) && cmd_reg == CMD_READ_QUAD
    |-> $past(cnt_reg, 1) == 5'h05)
    else $error("quad read dummy count wrong");
  a_dual_lanes: assert property (
    dfall && cmd_reg == CMD_READ_DUAL && sel |=> oe_n_reg == 4'hC)
    else $error("dual read lanes wrong");
  a_quad_lanes: assert property (
    dfall && cmd_reg == CMD_READ_QUAD && sel |=> oe_n_reg == 4'h0)
    else $error("quad read lanes wrong");
  a_pause_quiet: assert property (
    paused |=> oe_n_reg == 4'hF)
    else $error("driving while paused");
  a_pin_lock: assert property (
    commit && cmd_reg == CMD_STATUS_WRITE && hw_lock
    |=> $stable(bp_reg) && $stable(status_write_disable_bit_reg))
    else $error("status changed under pin lock");
endmodule

//--- rtl/sflash_pkg.sv
package sflash_pkg;

  localparam logic [7:0] CMD_WRITE_ENABLE      = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE     = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ       = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] CMD_READ              = 8'h03;
  localparam logic [7:0] CMD_READ_FAST         = 8'h0B;
  localparam logic [7:0] CMD_READ_DUAL         = 8'hBB;
  localparam logic [7:0] CMD_READ_QUAD         = 8'hEB;
  localparam logic [7:0] CMD_PROGRAM           = 8'h02;
  localparam logic [7:0] CMD_ERASE_SECTOR      = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K         = 8'h52;
  localparam logic [7:0] CMD_ERASE_64K         = 8'hD8;
  localparam logic [7:0] CMD_ERASE_CHIP        = 8'h60;
  localparam logic [7:0] CMD_ERASE_CHIP_ALT    = 8'hC7;
  localparam logic [7:0] CMD_IDENTIFICATION_READ = 8'h9F;
  localparam logic [7:0] CMD_SIGNATURE_READ    = 8'hAB;
  localparam logic [7:0] CMD_MFR_DEV_READ      = 8'h90;
  localparam logic [7:0] CMD_MFR_DEV_READ_DUAL = 8'hEF;
  localparam logic [7:0] CMD_MFR_DEV_READ_QUAD = 8'hDF;

  localparam logic [4:0] ADDR_BITS   = 5'h18;
  localparam logic [4:0] DUMMY_FAST  = 5'h08;
  localparam logic [4:0] DUMMY_DUAL  = 5'h04;
  localparam logic [4:0] DUMMY_QUAD  = 5'h06;
  localparam logic [4:0] DUMMY_SIG   = 5'h18;
  localparam logic [8:0] PAGE_BYTES  = 9'h100;
  localparam logic [3:0] BP_RST      = 4'h0;
  localparam int         ARRAY_AW    = 19;
  localparam int         DATA_W      = 8;
  localparam int         FIFO_DEPTH  = 32;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PAGE,
    OP_SECTOR,
    OP_BLK32,
    OP_BLK64,
    OP_CHIP
  } op_kind_e;

endpackage

//--- rtl/byte_fifo_if.sv
`timescale 1ns/100ps
interface byte_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         flush;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fill (output in_valid, in_data, flush, out_ready,
                input  in_ready, out_valid, out_data);
  modport store (input  in_valid, in_data, flush, out_ready,
                 output in_ready, out_valid, out_data);
endinterface

//--- rtl/sflash_fifo.sv
`timescale 1ns/100ps
module sflash_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input wire logic   clk,
  input wire logic   sys_rst,
  byte_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  wire  [AW:0]  fill_lvl = wr_reg - rd_reg;
  wire          full     = fill_lvl == (AW+1)'(DEPTH);
  wire          empty    = wr_reg == rd_reg;
  wire          push     = port.in_valid && !full;
  wire          pop      = port.out_ready && !empty;

  assign port.in_ready  = !full;
  assign port.out_valid = !empty;
  assign port.out_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= port.in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || port.flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

//--- test/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  output logic            cs_n,
  output logic            sclk,
  input  wire logic [3:0] dout,
  input  wire logic [3:0] doe_n,
  output logic [3:0]      lvl
);
  logic [3:0] hout;
  logic [3:0] hoe;
  logic       idle;
  logic       wp_n;
  // shared lines, io3 pulled up, io2 held at wp_n
  assign lvl = ~doe_n & dout | doe_n & hoe & hout
             | doe_n & ~hoe & {1'b1, wp_n, ~hout[1:0]};
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hout = 4'h0;
    hoe  = 4'h0;
    idle = 1'b0;
    wp_n = 1'b1;
  end
  // mode 3 idles the clock high
  task automatic mode(input logic m);
    idle = m;
    sclk = m;
    #40;
  endtask
  task automatic pin(input logic v);
    wp_n = v;
    #40;
  endtask
  task automatic sh(input logic [7:0] b, input int n, input bit rd,
                    output logic [7:0] r);
    logic [7:0] t;
    logic [3:0] m;
    t = b;
    r = 8'h0;
    m = 4'(4'hF >> (4 - n));
    hoe = rd ? 4'h0 : m;
    repeat (8 / n) begin
      if (idle) sclk = 1'b0;
      hout = 4'(t[7:4] >> (4 - n));
      t = t << n;
      #40;
      r = (r << n) | 8'(n == 1 ? 4'(lvl[1]) : lvl & m);
      sclk = 1'b1;
      #40;
      if (!idle) sclk = 1'b0;
    end
  endtask
  task automatic dummy(input int k);
    repeat (k) begin
      if (idle) sclk = 1'b0;
      #40;
      sclk = 1'b1;
      #40;
      if (!idle) sclk = 1'b0;
    end
  endtask
  task automatic sel(input logic v);
    #40;
    cs_n = v;
    hoe = 4'h0;
    #40;
  endtask
endmodule

//--- test/sflash_front_end_tb.sv
`timescale 1ns/100ps
module sflash_front_end_tb;
  import sflash_pkg::*;
  logic        clk, sys_rst, cs_n, sclk, prog_ready, array_done;
  logic        prog_valid, op_start, page_cancel, standby, quad_enable;
  logic        op_in_progress_flag, write_enable_latch;
  logic [3:0]  dout, doe_n, lvl, block_protect_bits;
  logic [18:0] array_rd_addr, op_addr;
  logic [7:0]  array_rd_data, prog_data, r;
  op_kind_e    op_kind;
  int          failures, samples_checked, starts, cancels;
  logic [7:0]  got[$];
  assign array_rd_data = array_rd_addr[7:0] ^ 8'h5A;
  spi_host_model h (.cs_n, .sclk, .dout, .doe_n, .lvl);
  sflash_front_end #(.MFR_CODE(8'h5E), .DEV_TYPE(8'h71),
    .DEV_CAP(8'h12), .DEV_SIG(8'h12)) dut (
    .clk, .sys_rst, .cs_n, .sclk, .array_rd_addr, .array_rd_data,
    .serial_in_io0_in(lvl[0]), .serial_in_io0_out(dout[0]),
    .serial_in_io0_oe_n(doe_n[0]), .serial_out_io1_in(lvl[1]),
    .serial_out_io1_out(dout[1]), .serial_out_io1_oe_n(doe_n[1]),
    .write_protect_n_io2_in(lvl[2]), .write_protect_n_io2_out(dout[2]),
    .write_protect_n_io2_oe_n(doe_n[2]), .pause_n_io3_in(lvl[3]),
    .pause_n_io3_out(dout[3]), .pause_n_io3_oe_n(doe_n[3]),
    .prog_valid, .prog_ready, .prog_data, .op_start, .op_kind,
    .op_addr, .page_cancel, .array_done, .standby, .quad_enable,
    .op_in_progress_flag, .write_enable_latch, .block_protect_bits);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (prog_valid && prog_ready) got.push_back(prog_data);
    if (op_start) starts++;
    if (page_cancel) cancels++;
  end
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tx(input logic [7:0] b, input int n = 1);
    h.sh(b, n, 1'b0, r);
  endtask
  task automatic t_id;
    logic [7:0] c[3] = '{CMD_IDENTIFICATION_READ, CMD_SIGNATURE_READ,
                         CMD_MFR_DEV_READ};
    logic [7:0] e[6] = '{8'h5E, 8'h71, 8'h12, 8'h12, 8'h5E, 8'h12};
    int nb[3] = '{3, 1, 2};
    int j = 0;
    for (int i = 0; i < 3; i++) begin
      h.sel(1'b0);
      tx(c[i]);
      if (i == 2) begin
        repeat (3) tx(8'h00);
      end else begin
        h.dummy(i == 0 ? 0 : 24);
      end
      repeat (nb[i]) begin
        h.sh(8'h0, 1, 1'b1, r);
        chk(e[j++], r);
      end
      h.sel(1'b1);
    end
    $display("test id done");
  endtask
  task automatic t_rd;
    logic [7:0] c[3] = '{CMD_READ_FAST, CMD_READ_DUAL, CMD_READ_QUAD};
    int n[3] = '{1, 2, 4};
    int d[3] = '{8, 4, 6};
    int x;
    for (int i = 0; i < 4; i++) begin
      x = i % 3;
      h.mode(i == 3);
      h.sel(1'b0);
      tx(c[x]);
      tx(8'h00, n[x]);
      tx(8'h00, n[x]);
      tx(8'(16 + i), n[x]);
      h.dummy(d[x]);
      for (int k = 0; k < 2; k++) begin
        h.sh(8'h0, n[x], 1'b1, r);
        chk(8'(16 + i + k) ^ 8'h5A, r);
      end
      h.sel(1'b1);
    end
    h.mode(1'b0);
    $display("test read done");
  endtask
  task automatic t_op;
    logic [7:0] c[5] = '{CMD_PROGRAM, CMD_ERASE_SECTOR, CMD_ERASE_32K,
                         CMD_ERASE_64K, CMD_ERASE_CHIP};
    op_kind_e q[5] = '{OP_PAGE, OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP};
    int s;
    int k;
    int pc;
    for (int i = 0; i < 6; i++) begin
      k = i == 0 ? 0 : i - 1;
      s = starts;
      pc = cancels;
      got.delete();
      if (i > 0) begin
        h.sel(1'b0);
        tx(CMD_WRITE_ENABLE);
        h.sel(1'b1);
      end
      chk(8'(i > 0), 8'(write_enable_latch));
      @(negedge clk);
      prog_ready = i != 1;
      h.sel(1'b0);
      tx(c[k]);
      if (k < 4) begin
        tx(8'h01);
        tx(8'h23);
        tx(8'h45);
      end
      if (k == 0) begin
        tx(8'h3C);
        tx(8'hC3);
      end
      h.sel(1'b1);
      repeat (4) @(negedge clk);
      chk(8'(i > 0), 8'(starts - s));
      chk(8'(i == 0), 8'(cancels - pc));
      if (i == 0) continue;
      chk(8'(q[k]), 8'(op_kind));
      chk(8'h1, 8'(op_in_progress_flag));
      chk(8'h0, 8'(standby));
      if (k == 0) begin
        chk(8'h45, op_addr[7:0]);
        chk(8'h1, 8'(prog_valid));
        prog_ready = 1'b1;
        repeat (4) @(negedge clk);
        chk(8'h3C, got[0]);
        chk(8'hC3, got[1]);
      end
      array_done = 1'b1;
      @(negedge clk);
      array_done = 1'b0;
      repeat (4) @(negedge clk);
      chk(8'h0, 8'(op_in_progress_flag));
      chk(8'h0, 8'(write_enable_latch));
      chk(8'h1, 8'(standby));
    end
    $display("test op done");
  endtask
  task automatic cmd1(input logic [7:0] c);
    h.sel(1'b0);
    tx(c);
    h.sel(1'b1);
  endtask
  task automatic wrsr(input logic [7:0] v);
    cmd1(CMD_WRITE_ENABLE);
    h.sel(1'b0);
    tx(CMD_STATUS_WRITE);
    tx(v);
    h.sel(1'b1);
  endtask
  task automatic t_prot;
    int s;
    wrsr(8'h04);
    chk(8'h1, 8'(block_protect_bits));
    chk(8'h0, 8'(write_enable_latch));
    h.sel(1'b0);
    tx(CMD_STATUS_READ);
    h.sh(8'h0, 1, 1'b1, r);
    h.sel(1'b1);
    chk(8'h04, r);
    s = starts;
    cmd1(CMD_WRITE_ENABLE);
    h.sel(1'b0);
    tx(CMD_ERASE_SECTOR);
    tx(8'h07);
    tx(8'h00);
    tx(8'h00);
    h.sel(1'b1);
    chk(8'h0, 8'(starts - s));
    chk(8'h1, 8'(write_enable_latch));
    wrsr(8'h80);
    h.pin(1'b0);
    wrsr(8'h84);
    chk(8'h0, 8'(block_protect_bits));
    h.pin(1'b1);
    wrsr(8'hC0);
    h.pin(1'b0);
    wrsr(8'hC4);
    chk(8'h1, 8'(block_protect_bits));
    chk(8'h1, 8'(quad_enable));
    h.pin(1'b1);
    wrsr(8'h00);
    chk(8'h0, 8'(quad_enable));
    $display("test protect done");
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    prog_ready = 1'b1;
    array_done = 1'b0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    t_id;
    t_rd;
    t_op;
    t_prot;
    stop_test;
  end
  initial begin
    #300000;
    failures++;
    stop_test;
  end
endmodule
